/* cfo_regs.svh */
// constants for the configuration forwarding and ordering block
// Behaviour
// - forward in-range primary Type 1 downstream unchanged
// - downstream range: above secondary, up to subordinate
// - upstream forwards Type 1 writes, ignores reads
// - config forwarding is delayed (PCI) or split (PCI-X)
// - special cycle needs 01b, 11111b, 111b, register
// - special bus number: secondary down, primary up
// - special replaces command, data carries message
// - special completes originator after target master abort
// - special cycles addressed to us are ignored
// - retried requests may complete in any order
// - no ordering between the two directions
// - posted write acceptance never waits on mastering
// - posted writes accepted whatever delayed progress is
// - PCI passing table for posted and delayed
// - PCI-X passing table for memory and split
// - relaxed ordering lets read completions pass writes
// - same sequence split completions stay address ordered
// - bus field 23:16; secondary match means Type 0
`ifndef CFO_REGS_SVH
`define CFO_REGS_SVH
// ==========================================================
// register offsets (byte addresses, low address bits decoded)
`define CFO_OFS_BUSNUM  8'h00
`define CFO_OFS_CTRL    8'h04
`define CFO_OFS_STATUS  8'h08
// ==========================================================
// field positions and reset values
`define CFO_F_PRI       7:0
`define CFO_F_SEC       15:8
`define CFO_F_SUB       23:16
`define CFO_F_PCIX_P    0
`define CFO_F_PCIX_S    1
`define CFO_F_RELAX     3:2
`define CFO_F_SPECREG   13:8
`define CFO_MASK_BUSNUM 32'h00FF_FFFF
`define CFO_MASK_CTRL   32'h0000_3F0F
`define CFO_RST_BUSNUM  32'h0000_0000
`define CFO_RST_CTRL    32'h0000_0000
// ==========================================================
// address and command encodings
`define CFO_F_BUS       23:16
`define CFO_F_DEV       15:11
`define CFO_F_FUNC      10:8
`define CFO_F_REG       7:2
`define CFO_TYPE1       2'h1
`define CFO_DEV_ALL     5'h1F
`define CFO_FUNC_ALL    3'h7
`define CFO_CMD_SPECIAL 4'h1
`define CFO_CMD_CFG_RD  4'hA
`define CFO_CMD_CFG_WR  4'hB
// ==========================================================
// ordering slots per direction and stored payload width
`define CFO_SLOTS       4
`define CFO_PAY_W       69
`endif

/* cfo_pkg.sv */
// types shared by the configuration forwarding and ordering block
package cfo_pkg;
    // ==========================================================
    // transaction classes that the ordering tables compare
    typedef enum logic [2:0] {
        CFO_PW  = 3'h0,   // posted / memory write
        CFO_DRR = 3'h1,   // delayed or split read request
        CFO_DWR = 3'h2,   // delayed or split write request
        CFO_DRC = 3'h3,   // read completion
        CFO_DWC = 3'h4    // write completion
    } cfo_cls_t;
endpackage

/* cfo_cfg_dec.sv */
// address phase decoder for Type 1 configuration and special cycles
`include "cfo_regs.svh"
module cfo_cfg_dec (
    input  wire logic        up,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  cmd,
    input  wire logic [7:0]  pri_bus,
    input  wire logic [7:0]  sec_bus,
    input  wire logic [7:0]  sub_bus,
    input  wire logic [5:0]  spec_reg,
    output logic             is_cfg,
    output logic             claim,
    output logic             to_type0,
    output logic             special
);
    logic [7:0] bus;     // target bus number
    logic       t1;      // Type 1 format
    logic       rd;      // configuration read
    logic       wr;      // configuration write
    logic       sfld;    // special cycle address fields
    logic       fwd;     // plain Type 1 forward
    logic       inrng;   // bus lies behind the secondary side
    // ==========================================================
    // field decode, pure combinational
    always_comb begin
        bus   = addr[`CFO_F_BUS];
        t1    = addr[1:0] == `CFO_TYPE1;
        rd    = cmd == `CFO_CMD_CFG_RD;
        wr    = cmd == `CFO_CMD_CFG_WR;
        inrng = (bus > sec_bus) && (bus <= sub_bus);
        sfld  = t1 && wr && (addr[`CFO_F_DEV] == `CFO_DEV_ALL)
              && (addr[`CFO_F_FUNC] == `CFO_FUNC_ALL)
              && (addr[`CFO_F_REG] == spec_reg);
        if (!up) begin
            // downstream: special on the secondary bus number
            special  = sfld && (bus == sec_bus);
            to_type0 = t1 && (rd || wr) && (bus == sec_bus) && !special;
            fwd      = t1 && (rd || wr) && inrng;
        end else begin
            // upstream: only writes, reads never claimed
            special  = sfld && (bus == pri_bus);
            to_type0 = 1'b0;
            fwd      = t1 && wr && !inrng && (bus != sec_bus)
                     && (bus != pri_bus);
        end
        is_cfg = rd || wr;
        claim  = fwd || special;
    end
endmodule // cfo_cfg_dec

/* cfo_slot_mem.sv */
// payload store for the ordering slots, registered read port
`include "cfo_regs.svh"
module cfo_slot_mem (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   we,
    input  wire logic [1:0]             waddr,
    input  wire logic [`CFO_PAY_W-1:0]  wdata,
    input  wire logic                   re,
    input  wire logic [1:0]             raddr,
    output logic      [`CFO_PAY_W-1:0]  rdata
);
    typedef struct packed {
        logic [`CFO_SLOTS-1:0][`CFO_PAY_W-1:0] mem;  // slot payloads
        logic [`CFO_PAY_W-1:0]                 rd;   // read register
    } cfo_mem_st_t;
    cfo_mem_st_t s_r;   // present state
    cfo_mem_st_t s_nxt; // next state
    // ==========================================================
    // write and read; a read of a slot written in the same cycle
    // returns the old payload, which the caller never needs
    always_comb begin
        s_nxt = s_r;
        if (we) begin
            s_nxt.mem[waddr] = wdata;
        end
        if (re) begin
            s_nxt.rd = s_r.mem[raddr];
        end
    end
    // ==========================================================
    // only the read register needs a defined reset value
    always_ff @(posedge clk) begin
        s_r <= s_nxt;
        if (rst) begin
            s_r.rd <= '0;
        end
    end
    assign rdata = s_r.rd;
endmodule // cfo_slot_mem

/* cfo_fwd_top.sv */
// configuration forwarding and transaction ordering core with AHB-Lite registers
`include "cfo_regs.svh"
module cfo_fwd_top (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // ahb-lite register slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // downstream: taken on the primary side
    input  wire logic        D_IN_VALID,
    input  wire logic [3:0]  PRIMARY_COMMAND_BYTE_ENABLES,
    input  wire logic [31:0] D_IN_ADDR,
    input  wire logic [31:0] D_IN_DATA,
    input  wire logic [2:0]  D_IN_CLASS,
    input  wire logic [4:0]  D_IN_SEQ,
    input  wire logic        D_IN_RO,
    output logic             D_IN_READY,
    output logic             D_IN_CLAIM,
    output logic             D_IN_TYPE0,
    output logic             D_OUT_VALID,
    input  wire logic        D_OUT_READY,
    output logic      [3:0]  D_OUT_CMD,
    output logic      [31:0] D_OUT_ADDR,
    output logic      [31:0] D_OUT_DATA,
    output logic      [2:0]  D_OUT_CLASS,
    output logic             D_OUT_SPLIT,
    input  wire logic        D_MABORT,
    output logic             D_CPL_RETRY,
    output logic             D_CPL_MSG,
    // upstream: taken on the secondary side
    input  wire logic        U_IN_VALID,
    input  wire logic [3:0]  SECONDARY_COMMAND_BYTE_ENABLES,
    input  wire logic [31:0] U_IN_ADDR,
    input  wire logic [31:0] U_IN_DATA,
    input  wire logic [2:0]  U_IN_CLASS,
    input  wire logic [4:0]  U_IN_SEQ,
    input  wire logic        U_IN_RO,
    output logic             U_IN_READY,
    output logic             U_IN_CLAIM,
    output logic             U_OUT_VALID,
    input  wire logic        U_OUT_READY,
    output logic      [3:0]  U_OUT_CMD,
    output logic      [31:0] U_OUT_ADDR,
    output logic      [31:0] U_OUT_DATA,
    output logic      [2:0]  U_OUT_CLASS,
    output logic             U_OUT_SPLIT,
    input  wire logic        U_MABORT,
    output logic             U_CPL_RETRY,
    output logic             U_CPL_MSG
);
    localparam int NS = `CFO_SLOTS;
    // ==========================================================
    // whole state of the block, except the slot payloads held in cfo_slot_mem, in one record
    typedef struct packed {
        logic [31:0]                busnum;  // bus number register
        logic [31:0]                ctrl;    // control register
        logic                       wpend;   // write data phase pending
        logic [7:0]                 waddr;   // its offset
        logic [31:0]                rdata;   // read data for data phase
        logic [1:0][NS-1:0]         vld;     // slot occupied
        logic [1:0][NS-1:0][2:0]    cls;     // slot class
        logic [1:0][NS-1:0][4:0]    seq;     // sequence id
        logic [1:0][NS-1:0]         ro;      // relaxed ordering attribute
        logic [1:0][NS-1:0][7:0]    alow;    // low address for completions
        logic [1:0][NS-1:0][NS-1:0] older;   // older[i][j]: j came before i
        logic [1:0]                 ovld;    // output stage holds a request
        logic [1:0][2:0]            ocls;    // class of the output request
        logic [1:0]                 spend;   // special cycle awaiting abort
        logic [1:0]                 cpl;     // completion pulse to originator
    } cfo_st_t;
    cfo_st_t s_r;   // present state
    cfo_st_t s_nxt; // next state
    // ==========================================================
    // per direction views of the ports, index 0 down, 1 up
    logic [1:0]       in_vld;     // request offered
    logic [1:0][3:0]  in_cmd;     // its bus command
    logic [1:0][31:0] in_addr;    // its address
    logic [1:0][31:0] in_data;    // its data
    logic [1:0][2:0]  in_cls;     // class for non-configuration traffic
    logic [1:0][4:0]  in_seq;     // sequence id
    logic [1:0]       in_ro;      // relaxed ordering attribute
    logic [1:0]       out_rdy;    // target side accepts
    logic [1:0]       mabort;     // target bus master abort
    logic [1:0]       dec_cfg;    // decoder: configuration command
    logic [1:0]       dec_claim;  // decoder: forward or special
    logic [1:0]       dec_t0;     // decoder: Type 0 conversion case
    logic [1:0]       dec_spec;   // decoder: special cycle
    logic [1:0]       claim;      // request will be stored
    logic [1:0]       rdy;        // a slot is available for it
    logic [1:0]       mwe;        // payload write
    logic [1:0][1:0]  mwa;        // payload write slot
    logic [1:0][1:0]  mra;        // payload read slot
    logic [1:0]       mre;        // payload read, the launch
    logic [1:0][`CFO_PAY_W-1:0] mwd;  // payload written
    logic [1:0][`CFO_PAY_W-1:0] mrd;  // payload of the output request
    logic [1:0]       split;      // initiating bus runs PCI-X
    logic             ahb_take;   // address phase taken
    assign in_vld  = {U_IN_VALID, D_IN_VALID};
    assign in_cmd  = {SECONDARY_COMMAND_BYTE_ENABLES, PRIMARY_COMMAND_BYTE_ENABLES};
    assign in_addr = {U_IN_ADDR, D_IN_ADDR};
    assign in_data = {U_IN_DATA, D_IN_DATA};
    assign in_cls  = {U_IN_CLASS, D_IN_CLASS};
    assign in_seq  = {U_IN_SEQ, D_IN_SEQ};
    assign in_ro   = {U_IN_RO, D_IN_RO};
    assign out_rdy = {U_OUT_READY, D_OUT_READY};
    assign mabort  = {U_MABORT, D_MABORT};
    // delayed in PCI, split in PCI-X, by the initiating bus
    assign split   = {s_r.ctrl[`CFO_F_PCIX_S], s_r.ctrl[`CFO_F_PCIX_P]};
    // ==========================================================
    // lowest set bit of a slot mask; used for free and eligible
    function automatic logic [2:0] cfo_first(input logic [NS-1:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction
    // ==========================================================
    // may a later entry pass an earlier one in the same direction
    function automatic logic cfo_pass(input logic [2:0] lc, input logic [2:0] ec,
                                      input logic rlx, input logic sseq_low);
        logic r;
        r = 1'b1;
        if (ec == cfo_pkg::CFO_PW) begin
            r = (lc == cfo_pkg::CFO_DRC) && rlx;
        end else if (lc == cfo_pkg::CFO_DWR && ec == cfo_pkg::CFO_DWR) begin
            r = 1'b0;
        end else if (lc == cfo_pkg::CFO_DWC && ec == cfo_pkg::CFO_DWC) begin
            r = 1'b0;
        end else if (lc == cfo_pkg::CFO_DRC && ec == cfo_pkg::CFO_DRC && sseq_low) begin
            r = 1'b0;
        end
        return r;
    endfunction
    // ==========================================================
    // decoders and payload stores, one pair per direction; the two
    // directions share nothing, so neither waits on the other
    for (genvar d = 0; d < 2; d++) begin : g_dir
        cfo_cfg_dec u_dec (
            .up       (d == 1),
            .addr     (in_addr[d]),
            .cmd      (in_cmd[d]),
            .pri_bus  (s_r.busnum[`CFO_F_PRI]),
            .sec_bus  (s_r.busnum[`CFO_F_SEC]),
            .sub_bus  (s_r.busnum[`CFO_F_SUB]),
            .spec_reg (s_r.ctrl[`CFO_F_SPECREG]),
            .is_cfg   (dec_cfg[d]),
            .claim    (dec_claim[d]),
            .to_type0 (dec_t0[d]),
            .special  (dec_spec[d])
        );
        cfo_slot_mem u_mem (
            .clk   (CLK_SYS),
            .rst   (RST),
            .we    (mwe[d]),
            .waddr (mwa[d]),
            .wdata (mwd[d]),
            .re    (mre[d]),
            .raddr (mra[d]),
            .rdata (mrd[d])
        );
    end
    // ==========================================================
    // next state: register bus, slot admission, ordering, launch
    always_comb begin
        logic [NS-1:0]  elig;     // slot may launch now
        logic [NS-1:0]  lmask;    // slot launching this cycle
        logic [2:0]     fre;      // first free slot
        logic [2:0]     sel;      // first eligible slot
        logic [2:0]     nfree;    // number of free slots
        logic           posted;   // incoming is a posted write
        logic           rlx;      // relaxed ordering in force
        logic           sseq;     // same sequence, earlier address lower
        logic [2:0]     c_in;     // class of the incoming request
        logic           outfire;  // output handshake
        elig = '0; lmask = '0; fre = 3'h0; sel = 3'h0; nfree = 3'h0;
        posted = 1'b0; rlx = 1'b0; sseq = 1'b0; c_in = 3'h0;
        outfire = 1'b0;
        s_nxt = s_r;
        claim = '0; rdy = '0; mwe = '0; mwa = '0; mra = '0; mre = '0; mwd = '0;
        ahb_take = HSEL && HTRANS[1] && HREADY;
        // register writes land in the data phase
        if (s_r.wpend) begin
            if (s_r.waddr == `CFO_OFS_BUSNUM) begin
                s_nxt.busnum = HWDATA & `CFO_MASK_BUSNUM;
            end else if (s_r.waddr == `CFO_OFS_CTRL) begin
                s_nxt.ctrl = HWDATA & `CFO_MASK_CTRL;
            end
        end
        s_nxt.wpend = ahb_take && HWRITE;
        if (ahb_take) begin
            s_nxt.waddr = HADDR[7:0];
        end
        // read data from the updated registers, so a write just before
        // a read of the same register is seen; unmapped reads give zero
        if (ahb_take && !HWRITE) begin
            case (HADDR[7:0])
                `CFO_OFS_BUSNUM: s_nxt.rdata = s_nxt.busnum;
                `CFO_OFS_CTRL:   s_nxt.rdata = s_nxt.ctrl;
                `CFO_OFS_STATUS: s_nxt.rdata = {20'h0_0000, s_r.ovld, s_r.spend,
                                                s_r.vld[1], s_r.vld[0]};
                default:         s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        for (int d = 0; d < 2; d++) begin
            // eligibility: checked against every older entry still held;
            // retried requests of free classes launch in any order
            for (int i = 0; i < NS; i++) begin
                elig[i] = s_r.vld[d][i];
                for (int j = 0; j < NS; j++) begin
                    rlx  = (s_r.ctrl[`CFO_F_PCIX_P] ^ s_r.ctrl[`CFO_F_PCIX_S])
                         ? s_r.ctrl[2 + d] : s_r.ro[d][i];
                    sseq = split[d] && (s_r.seq[d][j] == s_r.seq[d][i])
                         && (s_r.alow[d][j] < s_r.alow[d][i]);
                    if (s_r.vld[d][j] && s_r.older[d][i][j]
                        && !cfo_pass(s_r.cls[d][i], s_r.cls[d][j], rlx, sseq)) begin
                        elig[i] = 1'b0;
                    end
                end
            end
            sel     = cfo_first(elig);
            outfire = s_r.ovld[d] && out_rdy[d];
            lmask   = '0;
            if (sel[2] && (!s_r.ovld[d] || out_rdy[d])) begin
                lmask[sel[1:0]]         = 1'b1;
                mre[d]                  = 1'b1;
                mra[d]                  = sel[1:0];
                s_nxt.ovld[d]           = 1'b1;
                s_nxt.ocls[d]           = s_r.cls[d][sel[1:0]];
                s_nxt.vld[d][sel[1:0]]  = 1'b0;
            end else if (outfire) begin
                s_nxt.ovld[d] = 1'b0;
            end
            for (int i = 0; i < NS; i++) begin
                s_nxt.older[d][i] = s_r.older[d][i] & ~lmask;
            end
            // special cycle taken by the target: wait for the master abort, then
            // complete the originator; a special newly taken by the target wins over the abort
            s_nxt.cpl[d]   = s_r.spend[d] && mabort[d];
            s_nxt.spend[d] = (s_r.spend[d] && !mabort[d])
                           || (outfire && mrd[d][`CFO_PAY_W-1]);
            // admission of the incoming request
            c_in = in_cls[d];
            if (dec_cfg[d]) begin
                c_in = (in_cmd[d] == `CFO_CMD_CFG_WR) ? cfo_pkg::CFO_DWR
                     : cfo_pkg::CFO_DRR;
            end
            claim[d] = dec_cfg[d] ? dec_claim[d]
                     : (in_cmd[d] != `CFO_CMD_SPECIAL);
            posted = c_in == cfo_pkg::CFO_PW;
            nfree  = 3'h0;
            for (int i = 0; i < NS; i++) begin
                nfree = nfree + {2'h0, !s_r.vld[d][i]};
            end
            fre = cfo_first(~s_r.vld[d]);
            // one slot stays reserved for posted writes, so a queue full of
            // non-posted work can never hold a posted write off
            rdy[d] = !claim[d] || (posted ? fre[2] : (nfree > 3'h1));
            if (in_vld[d] && claim[d] && rdy[d]) begin
                mwe[d]                      = 1'b1;
                mwa[d]                      = fre[1:0];
                mwd[d]                      = {dec_cfg[d] && dec_spec[d],
                                               dec_spec[d] ? `CFO_CMD_SPECIAL
                                                           : in_cmd[d],
                                               in_addr[d], in_data[d]};
                s_nxt.vld[d][fre[1:0]]      = 1'b1;
                s_nxt.cls[d][fre[1:0]]      = c_in;
                s_nxt.seq[d][fre[1:0]]      = in_seq[d];
                s_nxt.ro[d][fre[1:0]]       = in_ro[d];
                s_nxt.alow[d][fre[1:0]]     = in_addr[d][7:0];
                s_nxt.older[d][fre[1:0]]    = s_r.vld[d] & ~lmask;
            end
        end
    end
    // ==========================================================
    // the single state register
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            s_r        <= '0;
            s_r.busnum <= `CFO_RST_BUSNUM;
            s_r.ctrl   <= `CFO_RST_CTRL;
        end else begin
            s_r <= s_nxt;
        end
    end
    // ==========================================================
    // outputs; zero wait state slave, always OKAY
    assign HRDATA      = s_r.rdata;
    assign HREADYOUT   = 1'b1;
    assign HRESP       = 1'b0;
    assign D_IN_READY  = rdy[0];
    assign U_IN_READY  = rdy[1];
    assign D_IN_CLAIM  = D_IN_VALID && claim[0];
    assign U_IN_CLAIM  = U_IN_VALID && claim[1];
    assign D_IN_TYPE0  = D_IN_VALID && dec_t0[0];
    assign D_OUT_VALID = s_r.ovld[0];
    assign U_OUT_VALID = s_r.ovld[1];
    assign D_OUT_CMD   = mrd[0][67:64];
    assign U_OUT_CMD   = mrd[1][67:64];
    assign D_OUT_ADDR  = mrd[0][63:32];
    assign U_OUT_ADDR  = mrd[1][63:32];
    assign D_OUT_DATA  = mrd[0][31:0];
    assign U_OUT_DATA  = mrd[1][31:0];
    assign D_OUT_CLASS = s_r.ocls[0];
    assign U_OUT_CLASS = s_r.ocls[1];
    assign D_OUT_SPLIT = split[0];
    assign U_OUT_SPLIT = split[1];
    assign D_CPL_RETRY = s_r.cpl[0] && !split[0];
    assign D_CPL_MSG   = s_r.cpl[0] && split[0];
    assign U_CPL_RETRY = s_r.cpl[1] && !split[1];
    assign U_CPL_MSG   = s_r.cpl[1] && split[1];
endmodule // cfo_fwd_top

/* cfo_fwd_asserts.sv */
// concurrent checks on the forwarding core ports
module cfo_fwd_asserts (
    input wire logic CLK_SYS, RST, D_IN_VALID, D_IN_CLAIM, D_IN_TYPE0, D_OUT_VALID, D_OUT_READY,
    input wire logic D_OUT_SPLIT, D_MABORT, D_CPL_RETRY, D_CPL_MSG, U_IN_VALID, U_IN_CLAIM,
    input wire logic [3:0] PRIMARY_COMMAND_BYTE_ENABLES, SECONDARY_COMMAND_BYTE_ENABLES, D_OUT_CMD,
    input wire logic [31:0] D_OUT_ADDR
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // one clock domain, reset masks every check
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire dn_sp = D_IN_VALID && PRIMARY_COMMAND_BYTE_ENABLES == 4'h1;   // special offered down
    wire up_sp = U_IN_VALID && SECONDARY_COMMAND_BYTE_ENABLES == 4'h1;   // special offered up
    wire up_rd = U_IN_VALID && SECONDARY_COMMAND_BYTE_ENABLES == 4'hA;   // config read offered up
    sequence s_spec_out; D_OUT_VALID && D_OUT_READY && D_OUT_CMD == 4'h1; endsequence
    a_dn_spec_drop: assert property (dn_sp |-> !D_IN_CLAIM) else $error("special taken");
    a_up_spec_drop: assert property (up_sp |-> !U_IN_CLAIM) else $error("special taken");
    a_up_read_drop: assert property (up_rd |-> !U_IN_CLAIM) else $error("read taken");
    a_type0_free: assert property (D_IN_TYPE0 |-> !D_IN_CLAIM) else $error("type0 taken");
    a_out_hold: assert property (D_OUT_VALID && !D_OUT_READY |=> D_OUT_VALID && $stable(D_OUT_ADDR))
        else $error("output lost");
    a_cpl_pulse: assert property (D_CPL_MSG |=> !D_CPL_MSG) else $error("long completion");
    a_cpl_mode: assert property (D_CPL_MSG |-> D_OUT_SPLIT && $past(D_MABORT))
        else $error("bad completion");
    a_cpl_after: assert property (s_spec_out ##1 D_MABORT |=> D_CPL_RETRY || D_CPL_MSG)
        else $error("no completion");
endmodule // cfo_fwd_asserts
bind cfo_fwd_top cfo_fwd_asserts i_chk (.*);

/* cfo_far_end.sv */
// far-side target model: random stalls, master abort ends special cycles
module cfo_far_end (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       vld,
    input  wire logic [3:0] cmd,
    output logic            rdy = 1'b0,
    output logic            mab = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 32'h1d4beb02;   // fixed stream so runs repeat
    // stalls at random; nobody claims a special cycle, so it aborts next cycle
    always @(posedge clk) begin
        rdy <= !rst && ($random(seed) % 2 != 0);
        mab <= !rst && vld && rdy && cmd == 4'h1;
    end
endmodule // cfo_far_end

/* cfo_fwd_top_tb_top.sv */
// testbench: register access and table driven forwarding in both directions
module cfo_fwd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, hsel = 0, hwr = 0, hro;
    logic [1:0] htr = 0, ivld = 0, iro = 0, irdy, iclm, ovld, ordy, mab, cpl;
    logic [31:0] hadr = 0, hwd = 0, hrd;
    logic [1:0][3:0] icmd = 0, ocmd;
    logic [1:0][31:0] iadr = 0, idat = 0, oadr, odat;
    logic [1:0][2:0] icls = 0;
    logic [1:0][4:0] iseq = 0;
    logic [67:0] q[2][$];   // expected outputs per direction, oldest first
    int seed = 32'h1d4beb02, failures = 0, checks_done = 0, ncpl = 0;
    // direction, command, address, expected forwarded command (0 means dropped)
    logic [40:0] tbl[9] = '{{1'b0, 4'hA, 32'h0005_0101, 4'hA}, {1'b0, 4'hB, 32'h0006_0001, 4'h0},
        {1'b0, 4'hB, 32'h0002_0001, 4'h0}, {1'b0, 4'h1, 32'h0002_FF01, 4'h0},
        {1'b0, 4'hB, 32'h0003_0001, 4'hB}, {1'b0, 4'hB, 32'h0002_FF01, 4'h1},
        {1'b1, 4'hB, 32'h0007_0001, 4'hB}, {1'b1, 4'hA, 32'h0007_0001, 4'h0},
        {1'b1, 4'hB, 32'h0001_FF01, 4'h1}};
    cfo_fwd_top i_cfo_fwd_top (.CLK_SYS(clk), .RST(rst), .HSEL(hsel), .HADDR(hadr), .HTRANS(htr),
        .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(hro), .HRDATA(hrd), .HREADYOUT(hro),
        .HRESP(), .D_IN_VALID(ivld[0]), .PRIMARY_COMMAND_BYTE_ENABLES(icmd[0]),
        .D_IN_ADDR(iadr[0]), .D_IN_DATA(idat[0]), .D_IN_CLASS(icls[0]), .D_IN_SEQ(iseq[0]),
        .D_IN_RO(iro[0]), .D_IN_READY(irdy[0]), .D_IN_CLAIM(iclm[0]), .D_IN_TYPE0(),
        .D_OUT_VALID(ovld[0]), .D_OUT_READY(ordy[0]), .D_OUT_CMD(ocmd[0]), .D_OUT_ADDR(oadr[0]),
        .D_OUT_DATA(odat[0]), .D_OUT_CLASS(), .D_OUT_SPLIT(), .D_MABORT(mab[0]),
        .D_CPL_RETRY(), .D_CPL_MSG(cpl[0]), .U_IN_VALID(ivld[1]),
        .SECONDARY_COMMAND_BYTE_ENABLES(icmd[1]), .U_IN_ADDR(iadr[1]), .U_IN_DATA(idat[1]),
        .U_IN_CLASS(icls[1]), .U_IN_SEQ(iseq[1]), .U_IN_RO(iro[1]), .U_IN_READY(irdy[1]),
        .U_IN_CLAIM(iclm[1]), .U_OUT_VALID(ovld[1]), .U_OUT_READY(ordy[1]), .U_OUT_CMD(ocmd[1]),
        .U_OUT_ADDR(oadr[1]), .U_OUT_DATA(odat[1]), .U_OUT_CLASS(), .U_OUT_SPLIT(),
        .U_MABORT(mab[1]), .U_CPL_RETRY(cpl[1]), .U_CPL_MSG());
    cfo_far_end i_far_dn (.clk(clk), .rst(rst), .vld(ovld[0]), .cmd(ocmd[0]), .rdy(ordy[0]),
        .mab(mab[0]));
    cfo_far_end i_far_up (.clk(clk), .rst(rst), .vld(ovld[1]), .cmd(ocmd[1]), .rdy(ordy[1]),
        .mab(mab[1]));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [67:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; d is write data or the expected read data
    task automatic ahb(input logic w, input logic [31:0] a, d);
        {hsel, htr, hwr, hadr} <= {1'b1, 2'h2, w, a};
        do @(posedge clk); while (hro !== 1'b1);
        {htr, hwd} <= {2'h0, d};
        do @(posedge clk); while (hro !== 1'b1);
        if (!w) chk(hrd, d);
    endtask
    // offer one request; only the selected direction is valid, the other is released
    task automatic send(input logic [40:0] t);
        logic d = t[40];
        {ivld, icmd[d], iadr[d]} <= {2'b01 << d, t[39:36], t[35:4]};
        {idat[d], icls[d], iseq[d], iro[d]} <= 41'({$random(seed), $random(seed)});
        do @(negedge clk); while (irdy[d] !== 1'b1);
        chk(iclm[d], t[3:0] != 0);
        if (t[3:0] != 0) q[d].push_back({t[3:0], t[35:4], idat[d]});
        @(posedge clk);
    endtask
    // a handshake due at the next rising edge is matched to the oldest note
    always @(negedge clk) begin
        if (!rst) ncpl += cpl[0] + cpl[1];
        for (int d = 0; d < 2; d++)
            if (ovld[d] && ordy[d]) chk({ocmd[d], oadr[d], odat[d]}, q[d].pop_front());
    end
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        ahb(0, 32'h0, 32'h0);
        ahb(1, 32'h0, 32'h0005_0201);
        ahb(1, 32'h4, 32'h0000_0001);
        ahb(0, 32'h0, 32'h0005_0201);
        ahb(0, 32'hC, 32'h0);
        foreach (tbl[i]) send(tbl[i]);
        ivld <= 0;
        repeat (40) @(posedge clk);
        chk(ncpl, 2);
        chk(q[0].size() + q[1].size(), 0);
        conclude();
    end
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule // cfo_fwd_top_tb_top
